// *** verilog/pcd_params.svh ***
`ifndef PCD_PARAMS_SVH
`define PCD_PARAMS_SVH

// register addresses carried in bits 6..3 of the first byte
`define PCD_ADDR_CTRL 4'h0
`define PCD_ADDR_LATCH 4'h1
`define PCD_ADDR_DIR 4'h2
`define PCD_ADDR_RXGAIN 4'h4
`define PCD_ADDR_TXGAIN 4'h5
`define PCD_ADDR_HYB1 4'h6
`define PCD_ADDR_HYB2 4'h7
`define PCD_ADDR_HYB3 4'h8
`define PCD_ADDR_RXSLOT 4'h9
`define PCD_ADDR_TXSLOT 4'hA

// first byte fields
`define PCD_B1_PDN 7
`define PCD_B1_ADDR_HI 6
`define PCD_B1_ADDR_LO 3
`define PCD_B1_RD 2
`define PCD_B1_LEN 1

// control register fields
`define PCD_CTRL_DN 3
`define PCD_CTRL_PP 0

// slot/port register fields
`define PCD_SLOT_PORT 6
`define PCD_SLOT_HI 5

// reset values
`define PCD_RST_CTRL 8'h89
`define PCD_RST_GAIN 8'h00
`define PCD_RST_HYB 8'h00
`define PCD_RST_DIR 6'h00
`define PCD_RST_LATCH 6'h00
`define PCD_RST_SLOT 8'h00

// timing
`define PCD_CLK_PERIOD_NS 20
`define PCD_MR_MIN_NS 1000
`define PCD_MR_CYCLES ((`PCD_MR_MIN_NS + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS)
`define PCD_BITS_PER_SLOT 8
`define PCD_PU_FRAMES 2'h2

`endif

// *** verilog/pcd_pkg.sv ***
package pcd_pkg;

    typedef enum logic [1:0] {CP_CMD, CP_DATA, CP_READ} pcd_cp_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [5:0] latch;
        logic [5:0] dir;
        logic [7:0] rx_gain;
        logic [7:0] tx_gain;
        logic [7:0] hyb1;
        logic [7:0] hyb2;
        logic [7:0] hyb3;
        logic [7:0] rx_slot;
        logic [7:0] tx_slot;
        logic pdn;
    } pcd_regs_t;

    // configuration handed to the bit-clock side
    typedef struct packed {
        logic pdn;
        logic dly;
        logic tx_port;
        logic [5:0] tx_slot;
        logic rx_port;
        logic [5:0] rx_slot;
    } pcd_cfg_t;

    typedef struct packed {
        logic [2:0] control_shift_clock_s;
        logic [1:0] cs_s;
        logic [1:0] ci_s;
        logic [1:0] mr_s;
        logic [5:0] pin_s1;
        logic [5:0] pin_s2;
        logic [1:0] ack_s;
        pcd_cp_state_t st;
        logic [2:0] bitcnt;
        logic [7:0] sh;
        logic [7:0] rd_sh;
        logic [3:0] addr;
        logic [5:0] mr_cnt;
        pcd_regs_t regs;
        pcd_cfg_t snap;
        logic req;
        logic co;
        logic co_oe;
        logic pa_en;
    } pcd_sys_t;

    typedef struct packed {
        logic [2:0] req_s;
        logic ack;
        pcd_cfg_t cfg;
        logic fsx_q;
        logic fsr_q;
        logic [9:0] tx_cnt;
        logic [9:0] rx_cnt;
        logic [1:0] pu_cnt;
        logic [7:0] tx_byte;
        logic tx_d;
        logic tx_oe_a;
        logic tx_oe_b;
        logic [2:0] tx_idx;
        logic rx_act;
        logic rx_last;
        logic [7:0] rx_sh;
        logic [7:0] rx_byte;
        logic rx_valid;
    } pcd_lnk_t;

    typedef struct packed {
        logic rx_bit;
        logic rx_take;
        logic rx_last;
        logic ext_a;
        logic ext_b;
    } pcd_neg_t;

endpackage

// *** verilog/pcd_top.sv ***
`timescale 1ns/100ps
`include "pcd_params.svh"
// Contract
// RQ1 - power-on reset leaves device powered down, ready for first control byte
// RQ2 - initial state: gains off, hybrid off, amp disabled, nondelayed timing
// RQ3 - latch direction presets all latch pins as inputs, undriven
// RQ4 - master reset held high at least 1 us restores initial state
// RQ5 - power bit set in any instruction enters powerdown
// RQ6 - powered down: both transmit outputs undriven, nonessential logic idle; slot counters and transmit data registers keep running
// RQ7 - powerdown keeps all registers; control port and latch outputs stay active
// RQ8 - each frame sync marks start of an 8-bit slot, width free
// RQ9 - control bit 3 selects timing; nondelayed slot starts at sync rise
// RQ10 - delayed timing: partner raises sync half a bit before slot
// RQ11 - slot counters locate assigned slots, only in delayed timing
// RQ12 - transmit and receive framing independent with separate syncs
// RQ13 - assigned transmit slot shifts byte out on rising bit clock
// RQ14 - driver enable pulls low first 7.5 bit times, else floats
// RQ15 - receive byte captured on eight falling edges in assigned slot
// RQ16 - instructions are two bytes except single-byte power command
// RQ17 - byte one: power bit 7, address 6..3, read bit 2, length bit 1
// RQ18 - eight control clock pulses with select low; input sampled falling
// RQ19 - second byte may have own select pulse or follow contiguously
// RQ20 - end of second byte's eighth pulse loads addressed register
// RQ21 - select may stay low; partner should raise it when idle
// RQ22 - read: eight more clocks, data driven out on rising edges
// RQ23 - readback output undriven whenever select is high
// RQ24 - power bit 0 requests powerup, 1 requests powerdown
// RQ25 - bit 7 shifts first on the control port
// RQ26 - after powerup transmit stays undriven until second transmit sync
// RQ27 - single-byte power command carries length bit 0
// RQ28 - register updates cross into bit clock domain through a synchronizer
module pcd_top
    import pcd_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic pcm_bclk_i,
    input wire logic master_reset_input_i,
    input wire logic control_shift_clock_i,
    input wire logic control_select_n_i,
    input wire logic control_serial_input_i,
    output logic readback_serial_output_o,
    output logic readback_serial_output_oe_o,
    input wire logic transmit_frame_sync_i,
    input wire logic receive_frame_sync_i,
    input wire logic [7:0] tx_sample_i,
    output logic pcm_tx_out_a_o,
    output logic pcm_tx_out_a_oe_o,
    output logic pcm_tx_out_b_o,
    output logic pcm_tx_out_b_oe_o,
    output logic line_driver_enable_n_a_o,
    output logic line_driver_enable_n_a_oe_o,
    output logic line_driver_enable_n_b_o,
    output logic line_driver_enable_n_b_oe_o,
    input wire logic pcm_rx_in_a_i,
    input wire logic pcm_rx_in_b_i,
    output logic [7:0] rx_sample_o,
    output logic rx_sample_valid_o,
    input wire logic [5:0] interface_latch_pins_i,
    output logic [5:0] interface_latch_pins_o,
    output logic [5:0] interface_latch_pins_oe_o,
    output logic [7:0] control_reg_o,
    output logic [7:0] tx_gain_o,
    output logic [7:0] rx_gain_o,
    output logic [23:0] hybrid_coef_o,
    output logic powerdown_o,
    output logic power_amp_enable_o
);

    localparam pcd_regs_t REGS_INIT = '{
        ctrl: `PCD_RST_CTRL, latch: `PCD_RST_LATCH, dir: `PCD_RST_DIR,
        rx_gain: `PCD_RST_GAIN, tx_gain: `PCD_RST_GAIN, hyb1: `PCD_RST_HYB,
        hyb2: `PCD_RST_HYB, hyb3: `PCD_RST_HYB, rx_slot: `PCD_RST_SLOT,
        tx_slot: `PCD_RST_SLOT, pdn: 1'b1};

    function automatic logic [7:0] reg_read(input pcd_regs_t r, input logic [3:0] a,
                                            input logic [5:0] pins);
        unique case (a)
            `PCD_ADDR_CTRL: reg_read = r.ctrl;
            `PCD_ADDR_LATCH: reg_read = {2'h0, (r.latch & r.dir) | (pins & ~r.dir)};
            `PCD_ADDR_DIR: reg_read = {2'h0, r.dir};
            `PCD_ADDR_RXGAIN: reg_read = r.rx_gain;
            `PCD_ADDR_TXGAIN: reg_read = r.tx_gain;
            `PCD_ADDR_HYB1: reg_read = r.hyb1;
            `PCD_ADDR_HYB2: reg_read = r.hyb2;
            `PCD_ADDR_HYB3: reg_read = r.hyb3;
            `PCD_ADDR_RXSLOT: reg_read = r.rx_slot;
            `PCD_ADDR_TXSLOT: reg_read = r.tx_slot;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // {hit, bit index}; a sync edge in delayed timing starts no slot yet
    function automatic logic [3:0] slot_hit(input logic det, input logic [9:0] cnt,
                                            input logic dly, input logic [5:0] slot);
        logic [9:0] p;
        logic [9:0] start;
        logic [9:0] off;
        p = det ? 10'h000 : (dly ? cnt - 10'h001 : cnt);
        start = dly ? {1'b0, slot, 3'h0} : 10'h000;
        off = p - start;
        slot_hit = {!(det && dly) && (p >= start) && (off < 10'(`PCD_BITS_PER_SLOT)),
                    off[2:0]};
    endfunction

    logic [1:0] rst_sync;
    logic rst_n;
    logic [1:0] lrst_sync;
    logic lrst_n;
    pcd_sys_t s;
    pcd_sys_t next_s;
    pcd_lnk_t l;
    pcd_lnk_t next_l;
    pcd_neg_t n;
    pcd_neg_t next_n;
    logic byte_done;
    logic [7:0] byte_val;
    logic mr_fire;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge pcm_bclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lrst_sync <= 2'h0;
        end else begin
            lrst_sync <= {lrst_sync[0], 1'b1};
        end
    end
    assign lrst_n = lrst_sync[1];

    always_comb begin
        next_s = s;
        byte_done = 1'b0;
        byte_val = {s.sh[6:0], s.ci_s[1]};
        next_s.control_shift_clock_s = {s.control_shift_clock_s[1:0], control_shift_clock_i};
        next_s.cs_s = {s.cs_s[0], control_select_n_i};
        next_s.ci_s = {s.ci_s[0], control_serial_input_i};
        next_s.mr_s = {s.mr_s[0], master_reset_input_i};
        next_s.pin_s1 = interface_latch_pins_i;
        next_s.pin_s2 = s.pin_s1;
        next_s.ack_s = {s.ack_s[0], l.ack};
        // RQ4 reset width count
        if (!s.mr_s[1]) begin
            next_s.mr_cnt = 6'h00;
        end else if (s.mr_cnt != 6'(`PCD_MR_CYCLES)) begin
            next_s.mr_cnt = s.mr_cnt + 6'h01;
        end
        // RQ23 select high floats readback
        next_s.co_oe = !s.cs_s[1];
        if (s.cs_s[1]) begin
            // RQ19 byte framing restarts, command state kept
            next_s.bitcnt = 3'h0;
        end else if (s.control_shift_clock_s[2] && !s.control_shift_clock_s[1]) begin
            // RQ18 sample on falling edge, RQ25 msb first
            next_s.sh = byte_val;
            next_s.bitcnt = s.bitcnt + 3'h1;
            byte_done = (s.bitcnt == 3'h7);
        end else if (!s.control_shift_clock_s[2] && s.control_shift_clock_s[1] && s.st == CP_READ) begin
            // RQ22 readback on rising edges
            next_s.co = s.rd_sh[7];
            next_s.rd_sh = {s.rd_sh[6:0], 1'b0};
        end
        if (byte_done) begin
            unique case (s.st)
                CP_CMD: begin
                    // RQ5 power bit in any instruction, RQ24 polarity
                    next_s.regs.pdn = byte_val[`PCD_B1_PDN];
                    // RQ16 length bit, RQ17 field layout, RQ27 single byte
                    if (byte_val[`PCD_B1_LEN]) begin
                        next_s.addr = byte_val[`PCD_B1_ADDR_HI:`PCD_B1_ADDR_LO];
                        next_s.st = byte_val[`PCD_B1_RD] ? CP_READ : CP_DATA;
                        next_s.rd_sh = reg_read(s.regs,
                            byte_val[`PCD_B1_ADDR_HI:`PCD_B1_ADDR_LO], s.pin_s2);
                    end
                end
                CP_DATA: begin
                    // RQ20 load addressed register
                    next_s.st = CP_CMD;
                    unique case (s.addr)
                        `PCD_ADDR_CTRL: next_s.regs.ctrl = byte_val;
                        `PCD_ADDR_LATCH: next_s.regs.latch = byte_val[5:0];
                        `PCD_ADDR_DIR: next_s.regs.dir = byte_val[5:0];
                        `PCD_ADDR_RXGAIN: next_s.regs.rx_gain = byte_val;
                        `PCD_ADDR_TXGAIN: next_s.regs.tx_gain = byte_val;
                        `PCD_ADDR_HYB1: next_s.regs.hyb1 = byte_val;
                        `PCD_ADDR_HYB2: next_s.regs.hyb2 = byte_val;
                        `PCD_ADDR_HYB3: next_s.regs.hyb3 = byte_val;
                        `PCD_ADDR_RXSLOT: next_s.regs.rx_slot = byte_val;
                        `PCD_ADDR_TXSLOT: next_s.regs.tx_slot = byte_val;
                        default: next_s.regs = s.regs;
                    endcase
                end
                CP_READ: next_s.st = CP_CMD;
                default: next_s.st = CP_CMD;
            endcase
        end
        // RQ4 restore initial state, RQ1 RQ2 RQ3 values
        mr_fire = (s.mr_cnt == 6'(`PCD_MR_CYCLES));
        if (mr_fire) begin
            next_s.regs = REGS_INIT;
            next_s.st = CP_CMD;
        end
        // RQ2 amp off only while down and disable bit set
        next_s.pa_en = !(next_s.regs.pdn && next_s.regs.ctrl[`PCD_CTRL_PP]);
        // RQ28 handshake: snapshot only moves once the last one was taken
        if (s.ack_s[1] == s.req) begin
            next_s.snap = '{pdn: s.regs.pdn, dly: !s.regs.ctrl[`PCD_CTRL_DN],
                tx_port: s.regs.tx_slot[`PCD_SLOT_PORT],
                tx_slot: s.regs.tx_slot[`PCD_SLOT_HI:0],
                rx_port: s.regs.rx_slot[`PCD_SLOT_PORT],
                rx_slot: s.regs.rx_slot[`PCD_SLOT_HI:0]};
            next_s.req = (next_s.snap != s.snap) ? !s.req : s.req;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.cs_s <= 2'h3;
            s.regs <= REGS_INIT;
            s.snap.pdn <= 1'b1;
            s.st <= CP_CMD;
        end else begin
            s <= next_s;
        end
    end

    logic [3:0] tx_h;
    logic [3:0] rx_h;
    logic fsx_det;
    logic fsr_det;
    logic [1:0] pu_next;
    logic tx_en;
    logic [7:0] tx_bits;

    always_comb begin
        next_l = l;
        next_l.req_s = {l.req_s[1:0], s.req};
        if (l.req_s[2] != l.req_s[1]) begin
            next_l.cfg = s.snap;
            next_l.ack = l.req_s[1];
        end
        // RQ12 separate sync detectors, RQ8 any width
        next_l.fsx_q = transmit_frame_sync_i;
        next_l.fsr_q = receive_frame_sync_i;
        fsx_det = transmit_frame_sync_i && !l.fsx_q;
        fsr_det = receive_frame_sync_i && !l.fsr_q;
        // RQ11 slot counters from frame start
        next_l.tx_cnt = fsx_det ? 10'h001 : (&l.tx_cnt ? l.tx_cnt : l.tx_cnt + 10'h001);
        next_l.rx_cnt = fsr_det ? 10'h001 : (&l.rx_cnt ? l.rx_cnt : l.rx_cnt + 10'h001);
        // RQ9 timing select; RQ11 slot number used only when delayed
        tx_h = slot_hit(fsx_det, l.tx_cnt, l.cfg.dly, l.cfg.dly ? l.cfg.tx_slot : 6'h00);
        rx_h = slot_hit(fsr_det, l.rx_cnt, l.cfg.dly, l.cfg.dly ? l.cfg.rx_slot : 6'h00);
        // RQ26 count syncs after powerup
        pu_next = l.pu_cnt;
        if (l.cfg.pdn) begin
            pu_next = 2'h0;
        end else if (fsx_det && l.pu_cnt != `PCD_PU_FRAMES) begin
            pu_next = l.pu_cnt + 2'h1;
        end
        next_l.pu_cnt = pu_next;
        // RQ6 nothing driven while down
        tx_en = !l.cfg.pdn && (pu_next == `PCD_PU_FRAMES);
        if (fsx_det) begin
            next_l.tx_byte = tx_sample_i;
        end
        // RQ13 msb first on rising edge
        tx_bits = fsx_det ? tx_sample_i : l.tx_byte;
        next_l.tx_d = tx_bits[3'h7 - tx_h[2:0]];
        next_l.tx_idx = tx_h[2:0];
        next_l.tx_oe_a = tx_en && tx_h[3] && !l.cfg.tx_port;
        next_l.tx_oe_b = tx_en && tx_h[3] && l.cfg.tx_port;
        // RQ15 falling-edge capture flagged here
        next_l.rx_act = !l.cfg.pdn && rx_h[3];
        next_l.rx_last = (rx_h[2:0] == 3'h7);
        next_l.rx_valid = 1'b0;
        if (n.rx_take) begin
            next_l.rx_sh = {l.rx_sh[6:0], n.rx_bit};
            if (n.rx_last) begin
                next_l.rx_byte = {l.rx_sh[6:0], n.rx_bit};
                next_l.rx_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge pcm_bclk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            l <= '0;
            l.cfg.pdn <= 1'b1;
            l.tx_cnt <= 10'h3FF;
            l.rx_cnt <= 10'h3FF;
        end else begin
            l <= next_l;
        end
    end

    always_comb begin
        next_n = n;
        next_n.rx_bit = l.cfg.rx_port ? pcm_rx_in_b_i : pcm_rx_in_a_i;
        next_n.rx_take = l.rx_act;
        next_n.rx_last = l.rx_last;
        // RQ14 half-bit extension to reach 7.5 bits
        next_n.ext_a = l.tx_oe_a && (l.tx_idx == 3'h6);
        next_n.ext_b = l.tx_oe_b && (l.tx_idx == 3'h6);
    end

    always_ff @(negedge pcm_bclk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            n <= '0;
        end else begin
            n <= next_n;
        end
    end

    assign readback_serial_output_o = s.co;
    assign readback_serial_output_oe_o = s.co_oe;
    assign pcm_tx_out_a_o = l.tx_d;
    assign pcm_tx_out_a_oe_o = l.tx_oe_a;
    assign pcm_tx_out_b_o = l.tx_d;
    assign pcm_tx_out_b_oe_o = l.tx_oe_b;
    // RQ14 open drain, low during bits 0..6 plus half of bit 7
    // the half bit needs both edges, so this enable is the or of two flops
    assign line_driver_enable_n_a_o = 1'b0;
    assign line_driver_enable_n_a_oe_o = (l.tx_oe_a && l.tx_idx != 3'h7) || n.ext_a;
    assign line_driver_enable_n_b_o = 1'b0;
    assign line_driver_enable_n_b_oe_o = (l.tx_oe_b && l.tx_idx != 3'h7) || n.ext_b;
    assign rx_sample_o = l.rx_byte;
    assign rx_sample_valid_o = l.rx_valid;
    // RQ3 RQ7 latches follow direction, live in powerdown
    assign interface_latch_pins_o = s.regs.latch;
    assign interface_latch_pins_oe_o = s.regs.dir;
    assign control_reg_o = s.regs.ctrl;
    assign tx_gain_o = s.regs.tx_gain;
    assign rx_gain_o = s.regs.rx_gain;
    assign hybrid_coef_o = {s.regs.hyb3, s.regs.hyb2, s.regs.hyb1};
    assign powerdown_o = s.regs.pdn;
    assign power_amp_enable_o = s.pa_en;

    sequence seq_ts_low7;
        line_driver_enable_n_a_oe_o [*7];
    endsequence

    // last half bit: only the falling-edge flop holds the enable, then it lets go
    sequence seq_ts_half;
        n.ext_a ##1 (l.tx_oe_a && !line_driver_enable_n_a_oe_o);
    endsequence

    chk_init_state: assert property (@(posedge clk_i) $rose(rst_n) |-> // RQ1
        powerdown_o && control_reg_o == `PCD_RST_CTRL && interface_latch_pins_oe_o == 6'h00)
        else $error("initial state wrong after reset");
    chk_mr_restore: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ4
        mr_fire |=> powerdown_o && tx_gain_o == `PCD_RST_GAIN && hybrid_coef_o == 24'h0)
        else $error("master reset did not restore state");
    chk_pdn_bit: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ5
        byte_done && s.st == CP_CMD && !mr_fire |=> powerdown_o == $past(byte_val[7]))
        else $error("power bit not applied");
    chk_regs_kept: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ7
        powerdown_o && !byte_done && !mr_fire |=> $stable(s.regs))
        else $error("register changed in powerdown");
    chk_write_load: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ20
        byte_done && s.st == CP_DATA && s.addr == `PCD_ADDR_TXGAIN && !mr_fire
        |=> tx_gain_o == $past(byte_val)) else $error("write not loaded");
    chk_co_float: assert property (@(posedge clk_i) disable iff (!rst_n) // RQ23
        s.cs_s[1] |=> !readback_serial_output_oe_o) else $error("readback driven");
    chk_tx_quiet: assert property (@(posedge pcm_bclk_i) disable iff (!lrst_n) // RQ6
        l.cfg.pdn |=> !pcm_tx_out_a_oe_o && !pcm_tx_out_b_oe_o)
        else $error("transmit driven in powerdown");
    chk_ts_width: assert property (@(posedge pcm_bclk_i) disable iff (!lrst_n) // RQ14
        $rose(l.tx_oe_a) && l.tx_idx == 3'h0 |-> seq_ts_low7 ##0 seq_ts_half ##1 !l.tx_oe_a)
        else $error("driver enable width wrong");

endmodule

// *** testbench/pcd_backplane.sv ***
`timescale 1ns/100ps
module pcd_backplane (
    output logic bclk_o,
    output logic fsx_o,
    output logic fsr_o,
    output logic rx_a_o,
    output logic rx_b_o,
    input wire logic tx_a_i,
    input wire logic tx_a_oe_i,
    input wire logic ld_a_oe_i,
    input wire logic tx_b_i,
    input wire logic tx_b_oe_i,
    input wire logic ld_b_oe_i
);
    logic busy;
    // bit clock runs free, a tdm backplane never stops it between frames
    initial begin
        bclk_o = 1'b0;
        // offset keeps its edges off the system clock's
        #1.7;
        forever #3 bclk_o = ~bclk_o;
    end
    initial begin
        busy = 1'b0;
        fsx_o = 1'b0;
        fsr_o = 1'b0;
        rx_a_o = 1'b0;
        rx_b_o = 1'b1;
    end
    // idle data lines toggle so a stale bit never passes as data
    always @(posedge bclk_o) begin
        if (!busy) begin
            rx_a_o <= ~rx_a_o;
            rx_b_o <= ~rx_b_o;
        end
    end
    task automatic frame(input logic [7:0] rxd, input int first, input bit pb,
            output logic [7:0] txd, output logic [8:0] oe, output logic [1:0] ld);
        busy = 1'b1;
        @(negedge bclk_o);
        // sync one bit wide; raised half a bit ahead of the slot
        fsx_o = 1'b1;
        fsr_o = 1'b1;
        for (int k = 0; k < first + 9; k++) begin
            @(posedge bclk_o);
            if (k < 8) rx_a_o <= rxd[7-k];
            @(negedge bclk_o);
            fsx_o = 1'b0;
            fsr_o = 1'b0;
            // watch the slot window and the bit after it on the chosen port
            if (k >= first && k < first + 8) txd = {txd[6:0], pb ? tx_b_i : tx_a_i};
            if (k >= first) oe[k-first] = pb ? tx_b_oe_i : tx_a_oe_i;
            if (k == first) ld[0] = pb ? ld_b_oe_i : ld_a_oe_i;
            if (k == first + 8) ld[1] = pb ? ld_b_oe_i : ld_a_oe_i;
        end
        busy = 1'b0;
        repeat (20) @(negedge bclk_o);
    endtask
endmodule

// *** testbench/pcm_codec_digital_interface_bench.sv ***
`timescale 1ns/100ps
`include "pcd_params.svh"
module pcm_codec_digital_interface_bench;
    logic clk, arst_n, mr, control_shift_clock, cs_n, ci, transmit_frame_sync, receive_frame_sync, bclk, rxa, rxb, co, co_oe;
    logic txa, txa_oe, txb, txb_oe, lda, lda_oe, ldb, ldb_oe, rxv, pd, pa;
    logic [7:0] txs, rxs, ctl, tg, rg, r, td;
    logic [5:0] ilo, iloe;
    logic [23:0] hyb;
    logic [8:0] oe;
    logic [1:0] ld;
    int fail_count, check_count;
    pcd_top u_dut (.clk_i(clk), .arst_n_i(arst_n), .pcm_bclk_i(bclk),
        .master_reset_input_i(mr), .control_shift_clock_i(control_shift_clock), .control_select_n_i(cs_n),
        .control_serial_input_i(ci), .readback_serial_output_o(co),
        .readback_serial_output_oe_o(co_oe), .transmit_frame_sync_i(transmit_frame_sync),
        .receive_frame_sync_i(receive_frame_sync), .tx_sample_i(txs), .pcm_tx_out_a_o(txa),
        .pcm_tx_out_a_oe_o(txa_oe), .pcm_tx_out_b_o(txb), .pcm_tx_out_b_oe_o(txb_oe),
        .line_driver_enable_n_a_o(lda), .line_driver_enable_n_a_oe_o(lda_oe),
        .line_driver_enable_n_b_o(ldb), .line_driver_enable_n_b_oe_o(ldb_oe),
        .pcm_rx_in_a_i(rxa), .pcm_rx_in_b_i(rxb), .rx_sample_o(rxs), .rx_sample_valid_o(rxv),
        .interface_latch_pins_i(6'h2A), .interface_latch_pins_o(ilo),
        .interface_latch_pins_oe_o(iloe), .control_reg_o(ctl), .tx_gain_o(tg),
        .rx_gain_o(rg), .hybrid_coef_o(hyb), .powerdown_o(pd), .power_amp_enable_o(pa));
    pcd_backplane u_bp (.bclk_o(bclk), .fsx_o(transmit_frame_sync), .fsr_o(receive_frame_sync), .rx_a_o(rxa),
        .rx_b_o(rxb), .tx_a_i(txa), .tx_a_oe_i(txa_oe), .ld_a_oe_i(lda_oe),
        .tx_b_i(txb), .tx_b_oe_i(txb_oe), .ld_b_oe_i(ldb_oe));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // slow control clock: design needs three system cycles per level
    task automatic cbyte(input logic [7:0] b, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            ci = b[i];
            repeat (4) @(negedge clk);
            control_shift_clock = 1'b1;
            repeat (4) @(negedge clk);
            control_shift_clock = 1'b0;
            repeat (4) @(negedge clk);
            q[i] = co;
        end
    endtask
    task automatic wr(input logic [7:0] b1, input logic [7:0] b2, input bit split);
        cs_n = 1'b0;
        cbyte(b1, r);
        if (split) begin
            cs_n = 1'b1;
            repeat (4) @(negedge clk);
            cs_n = 1'b0;
        end
        cbyte(b2, r);
        cs_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask
    task automatic one(input logic [7:0] b1);
        cs_n = 1'b0;
        cbyte(b1, r);
        cs_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask
    task automatic t_reset;
        chk("powerdown", 1, pd);
        chk("control", `PCD_RST_CTRL, ctl);
        chk("gains", 0, {tg, rg});
        chk("hybrid", 0, hyb);
        chk("amp", 0, pa);
        chk("latch oe", 0, iloe);
        chk("co oe", 0, co_oe);
    endtask
    task automatic t_regs;
        wr(8'hAA, 8'h5C, 0);
        chk("tx gain", 8'h5C, tg);
        wr(8'hC2, 8'h3C, 1);
        chk("hyb3", 8'h3C, hyb[23:16]);
        wr(8'h92, 8'h15, 0);
        chk("dir", 8'h15, iloe);
        wr(8'h8A, 8'h2C, 0);
        chk("latch out", 8'h2C, ilo);
        cs_n = 1'b0;
        cbyte(8'hAE, r);
        cbyte(8'h00, r);
        chk("read oe", 1, co_oe);
        chk("readback", 8'h5C, r);
        cbyte(8'h8E, r);
        cbyte(8'h00, r);
        chk("latch read", 8'h2E, r);
        cs_n = 1'b1;
        repeat (6) @(negedge clk);
        chk("co float", 0, co_oe);
        chk("still down", 1, pd);
    endtask
    task automatic t_power;
        one(8'h00);
        chk("powerup", 0, pd);
        one(8'h80);
        chk("powerdown", 1, pd);
        chk("kept gain", 8'h5C, tg);
        chk("kept dir", 8'h15, iloe);
        chk("kept latch", 8'h2C, ilo);
    endtask
    task automatic t_pcm;
        txs = 8'hA5;
        u_bp.frame(8'h00, 0, 0, td, oe, ld);
        chk("down oe", 0, oe);
        one(8'h00);
        repeat (20) @(negedge clk);
        u_bp.frame(8'h00, 0, 0, td, oe, ld);
        chk("first oe", 0, oe);
        u_bp.frame(8'h00, 0, 0, td, oe, ld);
        chk("second oe", 9'h0FF, oe);
        u_bp.frame(8'h3C, 0, 0, td, oe, ld);
        chk("tx byte", 8'hA5, td);
        chk("tx oe", 9'h0FF, oe);
        chk("drv en", 2'b01, ld);
        chk("drv level", 0, {lda, ldb});
        chk("rx byte", 8'h3C, rxs);
        wr(8'h02, 8'h81, 0);
        wr(8'h52, 8'h41, 0);
        repeat (20) @(negedge clk);
        chk("ctrl", 8'h81, ctl);
        chk("amp on", 1, pa);
        u_bp.frame(8'h00, 9, 0, td, oe, ld);
        chk("port a idle", 0, oe);
        txs = 8'h96;
        u_bp.frame(8'h00, 9, 1, td, oe, ld);
        chk("slot 1 byte", 8'h96, td);
        chk("slot 1 oe", 9'h0FF, oe);
        chk("port b drv en", 2'b01, ld);
    endtask
    task automatic t_mreset;
        mr = 1'b1;
        repeat (`PCD_MR_CYCLES + 4) @(negedge clk);
        mr = 1'b0;
        repeat (10) @(negedge clk);
        chk("mr gain", 0, tg);
        chk("mr ctrl", `PCD_RST_CTRL, ctl);
        chk("mr down", 1, pd);
        chk("mr dir", 0, iloe);
        chk("mr latch", 0, ilo);
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // run needs well under 100 us; a hang is cut short far beyond that
    initial begin
        #1000000;
        fail_count++;
        end_sim();
    end
    initial begin
        fail_count = 0;
        check_count = 0;
        arst_n = 1'b0;
        mr = 1'b0;
        control_shift_clock = 1'b0;
        cs_n = 1'b1;
        ci = 1'b0;
        txs = 8'h00;
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        repeat (10) @(negedge clk);
        t_reset();
        t_regs();
        t_power();
        t_pcm();
        t_mreset();
        end_sim();
    end
endmodule
